// *** rtl/pwm_reload_timer_defines.svh ***
// Register indices, field positions, reset values and widths for the PWM reload timer
`ifndef PWM_RELOAD_TIMER_DEFINES_SVH
`define PWM_RELOAD_TIMER_DEFINES_SVH

// Register indices; byte address on APB is four times the index
`define IDX_DUTY3          7'h74
`define IDX_DUTY2          7'h75
`define IDX_DUTY1          7'h76
`define IDX_DUTY0          7'h77
`define IDX_PWM_CTRL       7'h78
`define IDX_TIMER_CSR      7'h79
`define IDX_COUNTER_ACCESS 7'h7a
`define IDX_RELOAD_VALUE   7'h7b
`define IDX_CAPTURE_CSR    7'h7c
`define IDX_CAPTURE_VAL1   7'h7d
`define IDX_CAPTURE_VAL2   7'h7e

// APB address width in bits
`define APB_ADDR_W         12

// Timer control/status field positions
`define CSR_SRC_SEL_BIT    7
`define CSR_TAP_MSB        6
`define CSR_TAP_LSB        4
`define CSR_RUN_BIT        3
`define CSR_FORCE_BIT      2
`define CSR_OVF_IE_BIT     1
`define CSR_OVF_FLAG_BIT   0

// Capture control/status field positions
`define CCSR_EDGE_LSB      4
`define CCSR_IE_LSB        2
`define CCSR_FLAG_LSB      0

// Reset values and counter top value
`define RST_BYTE           8'h00
`define RST_PRESCALER      7'h00
`define COUNTER_TOP        8'hff

`endif

// *** rtl/pwm_reload_timer_pkg.sv ***
// Types for the PWM reload timer
package pwm_reload_timer_pkg;

  typedef logic [7:0] byte_t;

  // Whole state of the timer in one register bank
  typedef struct packed {
    logic [2:0]      ext_sync;      // External clock sync chain plus edge tap
    logic [1:0]      cap_sync0;     // Capture pin first sync stage
    logic [1:0]      cap_sync1;     // Capture pin second sync stage
    logic [1:0]      cap_prev;      // Capture pin edge tap
    logic [6:0]      prescaler;     // Seven-bit prescaler
    byte_t           counter;       // Reload counter
    byte_t           reload_value;  // Reload value
    logic [3:0][7:0] duty_value;    // Software duty values
    logic [3:0][7:0] compare_value; // Hidden compare values
    logic [3:0]      out_enable;    // PWM output enables
    logic [3:0]      out_polarity;  // PWM output polarity
    logic            clock_source_select;
    logic [2:0]      prescale_tap_select;
    logic            counter_run_enable;
    logic            overflow_irq_enable;
    logic            overflow_flag;
    logic [1:0]      capture_edge_select;
    logic [1:0]      capture_irq_enable;
    logic [1:0]      capture_flag;
    logic [1:0][7:0] capture_value;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [3:0]      pwm_level;
    logic [3:0]      pwm_oe;
    logic            ovf_irq;
    logic            cap_irq;
    logic            wake;
  } timer_state_s;

endpackage

// *** rtl/pwm_reload_timer.sv ***
// PWM auto-reload timer with APB register access, four PWM outputs and two captures
//
// Overview of operation
// - Eight-bit up-counter advances on prescaler tick
// - Overflow reloads counter, prescaler left alone
// - Counter readable and writable while running
// - Seven-bit prescaler, tap selects divide 2^n
// - Source select picks CPU or external clock
// - Run enable clear freezes prescaler and counter
// - Reset clears counter, prescaler, selects CPU
// - Force reload or counter write clears prescaler
// - Hidden compares copied from duty at overflow
// - Per-channel enable drives push-pull output
// - Shared period is 256 minus reload value
// - Overflow sets inverse of polarity, compare restores
// - No PWM waveform while in Halt
// - Overflow sets flag, gated overflow interrupt
// - External events counted, flag after 256-reload
// - Capture edge latches counter, sets flag
// - Edge select and interrupt enable per channel
// - Capture blocked until value read; read clears
// - Capture interrupt held while flag and enable
// - Enabled capture edge wakes from Halt
// - Reading control/status clears overflow flag
// - Force reload is write-only, reads zero
// - Polarity change inverts output at once
// - Edge select one is rising, zero falling
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pwm_reload_timer_defines.svh"

module pwm_reload_timer (
  input  wire logic                          ref_clk,           // 50 MHz CPU clock
  input  wire logic                          rst_b,             // Synchronous reset
  input  wire logic [`APB_ADDR_W-1:0]        paddr,             // APB byte address
  input  wire logic                          psel,              // APB select
  input  wire logic                          penable,           // APB access phase
  input  wire logic                          pwrite,            // APB write
  input  wire logic [31:0]                   pwdata,            // APB write data
  output logic [31:0]                        prdata,            // APB read data
  output logic                               pready,            // APB ready
  output logic                               pslverr,           // APB error, unmapped
  input  wire logic                          external_event_clock, // External clock pin
  input  wire logic [1:0]                    capture_input_pin, // Capture pins 1 and 2
  input  wire logic                          halt_mode,         // System in Halt
  output logic [3:0]                         pwm_out,           // PWM pin levels
  output logic [3:0]                         pwm_out_en,        // PWM pin drive enables
  output logic                               overflow_irq,      // Overflow interrupt
  output logic                               capture_irq,       // Capture interrupt
  output logic                               wake_req           // Halt wake request
);
  import pwm_reload_timer_pkg::*;

  timer_state_s q;
  timer_state_s d;

  // Bus decode helpers
  logic        in_map;
  logic [6:0]  idx;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  byte_t       wbyte;

  // Timing helpers
  logic        in_tick;
  logic        cnt_tick;
  logic [6:0]  tap_mask;
  logic        ovf_set;
  logic [1:0]  cap_edge;
  logic [1:0]  cap_take;
  logic [1:0]  icr_read;
  logic        csr_read;
  logic [3:0]  raw_level;

  assign idx   = paddr[8:2];
  assign wbyte = pwdata[7:0];
  // Access completes on the second access cycle, so one wait state per transfer
  assign acc   = psel & penable & q.pready;
  assign wr    = acc & pwrite & in_map;
  assign rd    = acc & ~pwrite & in_map;

  // Address map check; misaligned or out of window counts as unmapped
  always_comb begin
    in_map = 1'b0;
    if (paddr[1:0] == 2'b00 && paddr[`APB_ADDR_W-1:9] == '0) begin
      in_map = (idx >= `IDX_DUTY3) && (idx <= `IDX_CAPTURE_VAL2);
    end
  end

  // Read mux; force reload bit always reads back as zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (idx)
      `IDX_DUTY3:          rdata[7:0] = q.duty_value[3];
      `IDX_DUTY2:          rdata[7:0] = q.duty_value[2];
      `IDX_DUTY1:          rdata[7:0] = q.duty_value[1];
      `IDX_DUTY0:          rdata[7:0] = q.duty_value[0];
      `IDX_PWM_CTRL:       rdata[7:0] = {q.out_enable, q.out_polarity};
      `IDX_TIMER_CSR:      rdata[7:0] = {q.clock_source_select, q.prescale_tap_select,
                                         q.counter_run_enable, 1'b0,
                                         q.overflow_irq_enable, q.overflow_flag};
      `IDX_COUNTER_ACCESS: rdata[7:0] = q.counter;
      `IDX_RELOAD_VALUE:   rdata[7:0] = q.reload_value;
      `IDX_CAPTURE_CSR:    rdata[7:0] = {2'b00, q.capture_edge_select,
                                         q.capture_irq_enable, q.capture_flag};
      `IDX_CAPTURE_VAL1:   rdata[7:0] = q.capture_value[0];
      `IDX_CAPTURE_VAL2:   rdata[7:0] = q.capture_value[1];
      default:             rdata = 32'h0000_0000;
    endcase
  end

  // Prescaler input tick: every CPU cycle, or a synced external rising edge
  always_comb begin
    if (q.clock_source_select) begin
      in_tick = q.ext_sync[1] & ~q.ext_sync[2];
    end else begin
      in_tick = 1'b1;
    end
    // Frozen while not running; halted core also stops counting
    in_tick  = in_tick & q.counter_run_enable & ~halt_mode;
    tap_mask = 7'(({1'b0, 7'h7f} << q.prescale_tap_select) ^ 8'h7f);
    cnt_tick = in_tick && ((q.prescaler & tap_mask) == tap_mask);
    ovf_set  = cnt_tick && (q.counter == `COUNTER_TOP);
  end

  // Capture edge detection on synced pins
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Edge select one means rising, zero falling
      if (q.capture_edge_select[i]) begin
        cap_edge[i] = q.cap_sync1[i] & ~q.cap_prev[i];
      end else begin
        cap_edge[i] = ~q.cap_sync1[i] & q.cap_prev[i];
      end
      icr_read[i] = rd && (idx == (`IDX_CAPTURE_VAL1 + 7'(i)));
      // A read in the same cycle reopens the channel, so the edge is not lost
      cap_take[i] = cap_edge[i] & (~q.capture_flag[i] | icr_read[i]);
    end
    csr_read = rd && (idx == `IDX_TIMER_CSR);
  end

  // Level before polarity: high while counter is at or below compare
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      raw_level[c] = (q.counter <= q.compare_value[c]);
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    d = q;

    // Two-stage synchronisers, third stage used only for edges
    d.ext_sync  = {q.ext_sync[1:0], external_event_clock};
    d.cap_sync0 = capture_input_pin;
    d.cap_sync1 = q.cap_sync0;
    d.cap_prev  = q.cap_sync1;

    // Prescaler and counter
    if (in_tick) begin
      d.prescaler = q.prescaler + 7'h01;
    end
    if (cnt_tick) begin
      if (q.counter == `COUNTER_TOP) begin
        d.counter       = q.reload_value;
        d.compare_value = q.duty_value;
      end else begin
        d.counter = q.counter + 8'h01;
      end
    end

    // Register writes, applied at the completing edge; a write beats a tick
    if (wr) begin
      unique case (idx)
        `IDX_DUTY3:          d.duty_value[3] = wbyte;
        `IDX_DUTY2:          d.duty_value[2] = wbyte;
        `IDX_DUTY1:          d.duty_value[1] = wbyte;
        `IDX_DUTY0:          d.duty_value[0] = wbyte;
        `IDX_PWM_CTRL: begin
          d.out_enable   = wbyte[7:4];
          d.out_polarity = wbyte[3:0];
        end
        `IDX_TIMER_CSR: begin
          d.clock_source_select = wbyte[`CSR_SRC_SEL_BIT];
          d.prescale_tap_select = wbyte[`CSR_TAP_MSB:`CSR_TAP_LSB];
          d.counter_run_enable  = wbyte[`CSR_RUN_BIT];
          d.overflow_irq_enable = wbyte[`CSR_OVF_IE_BIT];
          // Force reload needs the run bit in the same write
          if (wbyte[`CSR_FORCE_BIT] && wbyte[`CSR_RUN_BIT]) begin
            d.counter   = q.reload_value;
            d.prescaler = `RST_PRESCALER;
          end
        end
        `IDX_COUNTER_ACCESS: begin
          d.counter   = wbyte;
          d.prescaler = `RST_PRESCALER;
        end
        `IDX_RELOAD_VALUE:   d.reload_value = wbyte;
        `IDX_CAPTURE_CSR: begin
          d.capture_edge_select = wbyte[`CCSR_EDGE_LSB+1:`CCSR_EDGE_LSB];
          d.capture_irq_enable  = wbyte[`CCSR_IE_LSB+1:`CCSR_IE_LSB];
        end
        default: begin
        end
      endcase
    end

    // Overflow flag: read clears, a coincident overflow wins
    d.overflow_flag = (q.overflow_flag & ~csr_read) | ovf_set;

    // Captures latch the live counter value
    for (int i = 0; i < 2; i++) begin
      if (cap_take[i]) begin
        d.capture_value[i] = q.counter;
      end
      d.capture_flag[i] = (q.capture_flag[i] & ~icr_read[i]) | cap_take[i];
    end

    // Outputs; polarity applied before the register so a change shows at the write's own edge
    for (int c = 0; c < 4; c++) begin
      // Polarity zero: high up to compare; Halt parks pin at inverse of polarity
      d.pwm_level[c] = halt_mode ? ~d.out_polarity[c]
                                 : (raw_level[c] ^ d.out_polarity[c]);
    end
    d.pwm_oe  = d.out_enable;
    d.ovf_irq = d.overflow_flag & d.overflow_irq_enable;
    d.cap_irq = |(d.capture_flag & d.capture_irq_enable);
    d.wake    = |(cap_take & d.capture_irq_enable);

    // APB slave: one wait state, data and error registered with ready
    d.pready  = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pslverr = ~in_map;
      d.prdata  = in_map ? rdata : 32'h0000_0000;
    end

    // Reset state, CPU clock selected
    if (!rst_b) begin
      d = '0;
      d.pwm_level = 4'hf;
    end
  end

  // Single state register
  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign pwm_out      = q.pwm_level;
  assign pwm_out_en   = q.pwm_oe;
  assign overflow_irq = q.ovf_irq;
  assign capture_irq  = q.cap_irq;
  assign wake_req     = q.wake;

endmodule

// *** test/pwm_timer_checker_assertions.sv ***
// Port checker for the PWM reload timer, bound into the design
`timescale 1ns/1ps
module pwm_timer_checker (
  input wire logic        ref_clk,      // Clock
  input wire logic        rst_b,        // Reset, active low
  input wire logic        psel,         // APB select
  input wire logic        penable,      // APB access
  input wire logic [31:0] prdata,       // Read data
  input wire logic        pready,       // Ready
  input wire logic        pslverr,      // Error
  input wire logic        halt_mode,    // Halt level
  input wire logic [3:0]  pwm_out,      // PWM levels
  input wire logic [3:0]  pwm_out_en,   // Drive enables
  input wire logic        overflow_irq, // Overflow request
  input wire logic        capture_irq,  // Capture request
  input wire logic        wake_req      // Wake pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Bus answer timing and content
  a_ready_second: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_empty: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper data");
  // Enables move only after a bus write
  a_oe_hold: assert property (!psel && !$past(psel) && !$past(psel, 2) |-> $stable(pwm_out_en))
    else $error("enable moved");
  // Waveform frozen while halted
  a_halt_still: assert property (halt_mode && $past(halt_mode) && !psel && !$past(psel, 2)
    |=> $stable(pwm_out)) else $error("pwm in halt");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake held");
  a_wake_irq: assert property (wake_req |-> ##[0:2] capture_irq)
    else $error("wake no irq");
  // Requests only drop after software touches the bus
  a_cap_hold: assert property (capture_irq && !psel && !$past(psel) |=> capture_irq)
    else $error("capture irq dropped");
  a_ovf_hold: assert property (overflow_irq && !psel && !$past(psel) |=> overflow_irq)
    else $error("overflow irq dropped");
endmodule

bind pwm_reload_timer pwm_timer_checker pwm_timer_checker_inst (.ref_clk, .rst_b, .psel,
  .penable, .prdata, .pready, .pslverr, .halt_mode, .pwm_out, .pwm_out_en, .overflow_irq,
  .capture_irq, .wake_req);

// *** test/pwm_load_model.sv ***
// Far side model: event clock source, capture sources, PWM loads
`timescale 1ns/1ps
module pwm_load_model (
  input  wire logic       ref_clk,   // Bench clock
  output logic            ext_clk,   // Event clock pin
  output logic [1:0]      cap_pin,   // Capture pins
  input  wire logic [3:0] pwm_out,   // Load levels
  input  wire logic [3:0] pwm_out_en // Load drive enables
);
  // Idle levels: channel one low, channel two high
  initial begin
    ext_clk = 1'b0;
    cap_pin = 2'b10;
  end
  // Slow pulses so the pin synchroniser never misses an edge
  task automatic pulse(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
  // Move one capture pin, then let w edges pass
  task automatic cap(input int c, input logic v, input int w);
    cap_pin[c] <= v;
    repeat (w) @(posedge ref_clk);
  endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the PWM reload timer
`timescale 1ns/1ps
`include "pwm_reload_timer_defines.svh"
module tb;
  logic                   ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic                   halt_mode = 0, pready, pslverr, ext_clk, rerr;
  logic                   overflow_irq, capture_irq, wake_req;
  logic [`APB_ADDR_W-1:0] paddr = '0;
  logic [31:0]            pwdata = '0, prdata, rdat;
  logic [1:0]             cap_pin;
  logic [3:0]             pwm_out, pwm_out_en;
  int                     err_count = 0, num_checks = 0, cyc = 0;

  always #10 ref_clk = ~ref_clk;
  pwm_reload_timer pwm_reload_timer_inst (.ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .external_event_clock(ext_clk),
    .capture_input_pin(cap_pin), .halt_mode, .pwm_out, .pwm_out_en, .overflow_irq,
    .capture_irq, .wake_req);
  pwm_load_model pwm_load_model_inst (.ref_clk, .ext_clk, .cap_pin, .pwm_out, .pwm_out_en);

  task automatic conclude();
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic [`APB_ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    apb({3'h0, i, 2'h0}, 1'b1, d);
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    apb({3'h0, i, 2'h0}, 1'b0, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  // Levels sampled mid-cycle, after the edge's updates
  task automatic pins(input logic [3:0] e);
    @(negedge ref_clk);
    chk({28'h0, pwm_out}, {28'h0, e});
    @(posedge ref_clk);
  endtask
  // High time and period of one channel, in clock cycles
  task automatic meas(input int c, input int hi, input int per);
    int h, p;
    h = 0;
    p = 0;
    while (pwm_out[c] !== 1'b0 && p < 900) begin
      @(posedge ref_clk);
      p++;
    end
    while (pwm_out[c] !== 1'b1 && p < 1800) begin
      @(posedge ref_clk);
      p++;
    end
    p = 0;
    while (pwm_out[c] === 1'b1 && p < 900) begin
      @(posedge ref_clk);
      h++;
      p++;
    end
    while (pwm_out[c] === 1'b0 && p < 900) begin
      @(posedge ref_clk);
      p++;
    end
    chk(h, hi);
    chk(p, per);
  endtask

  // Hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    pins(4'hf);
    chk({28'h0, pwm_out_en}, 32'h0);
    for (int i = 'h74; i <= 'h7e; i++) rd(7'(i), 8'h00);
    apb(12'h004, 1'b0, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    wr(`IDX_TIMER_CSR, 8'h04);
    rd(`IDX_TIMER_CSR, 8'h00);
    wr(`IDX_COUNTER_ACCESS, 8'h3c);
    repeat (5) @(posedge ref_clk);
    rd(`IDX_COUNTER_ACCESS, 8'h3c);
    // Duty kept above reload so every channel toggles
    wr(`IDX_RELOAD_VALUE, 8'hf0);
    wr(`IDX_PWM_CTRL, 8'hf8);
    for (int c = 0; c < 4; c++) begin
      wr(7'(`IDX_DUTY0 - c), 8'(8'hf8 - c));
      wr(`IDX_TIMER_CSR, {1'b0, 3'(c), 4'b1100});
      meas(c, (c == 3 ? 10 : 9 - c) << c, 16 << c);
    end
    chk({28'h0, pwm_out_en}, 32'hf);
    wr(`IDX_TIMER_CSR, 8'h00);
    wr(`IDX_COUNTER_ACCESS, 8'h00);
    pins(4'h7);
    wr(`IDX_PWM_CTRL, 8'hf0);
    pins(4'hf);
    wr(`IDX_RELOAD_VALUE, 8'hff);
    wr(`IDX_TIMER_CSR, 8'h7e);
    for (int n = 0; n < 400 && overflow_irq !== 1'b1; n++) @(posedge ref_clk);
    chk({31'h0, overflow_irq}, 32'h1);
    rd(`IDX_TIMER_CSR, 8'h7b);
    rd(`IDX_TIMER_CSR, 8'h7a);
    wr(`IDX_RELOAD_VALUE, 8'hfd);
    wr(`IDX_TIMER_CSR, 8'h8c);
    rd(`IDX_TIMER_CSR, 8'h88);
    pwm_load_model_inst.pulse(2);
    rd(`IDX_TIMER_CSR, 8'h88);
    pwm_load_model_inst.pulse(1);
    repeat (4) @(posedge ref_clk);
    rd(`IDX_TIMER_CSR, 8'h89);
    // Counter stopped before any halt
    wr(`IDX_TIMER_CSR, 8'h00);
    wr(`IDX_COUNTER_ACCESS, 8'h3c);
    wr(`IDX_CAPTURE_CSR, 8'h1c);
    pwm_load_model_inst.cap(0, 1'b1, 0);
    for (int n = 0; n < 20 && wake_req !== 1'b1; n++) @(posedge ref_clk);
    chk({31'h0, wake_req}, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, capture_irq}, 32'h1);
    rd(`IDX_CAPTURE_CSR, 8'h1d);
    wr(`IDX_COUNTER_ACCESS, 8'h40);
    pwm_load_model_inst.cap(0, 1'b0, 6);
    pwm_load_model_inst.cap(0, 1'b1, 6);
    rd(`IDX_CAPTURE_VAL1, 8'h3c);
    rd(`IDX_CAPTURE_CSR, 8'h1c);
    pwm_load_model_inst.cap(0, 1'b0, 6);
    pwm_load_model_inst.cap(1, 1'b0, 6);
    rd(`IDX_CAPTURE_CSR, 8'h1e);
    rd(`IDX_CAPTURE_VAL2, 8'h40);
    halt_mode <= 1'b1;
    pwm_load_model_inst.cap(1, 1'b1, 6);
    pwm_load_model_inst.cap(1, 1'b0, 0);
    for (int n = 0; n < 20 && wake_req !== 1'b1; n++) @(posedge ref_clk);
    chk({31'h0, wake_req}, 32'h1);
    halt_mode <= 1'b0;
    conclude();
  end
endmodule
